// *** src/scc_pkg.sv ***
// constants and types for the system control coprocessor register bank
package scc_pkg;

  // register address: low five bits are the number, high three the subnumber
  localparam int ADDR_W = 8;
  localparam int NUM_LSB = 0;
  localparam int NUM_W = 5;
  localparam int SEL_LSB = 5;
  localparam int SEL_W = 3;
  localparam int DATA_W = 64;
  localparam int WORD_W = 32;
  localparam int IDX_W = 6;
  localparam int SLOT_W = 7;

  // register numbers
  localparam logic [4:0] NUM_INDEX = 5'h00;
  localparam logic [4:0] NUM_RANDOM = 5'h01;
  localparam logic [4:0] NUM_CONTEXT = 5'h04;
  localparam logic [4:0] NUM_PAGE = 5'h05;
  localparam logic [4:0] NUM_WIRED = 5'h06;
  localparam logic [4:0] NUM_STATUS = 5'h0c;
  localparam logic [4:0] NUM_VECTOR = 5'h0f;
  localparam logic [4:0] NUM_CONFIG = 5'h10;
  localparam logic [4:0] NUM_EVENT = 5'h12;
  localparam logic [4:0] NUM_EVMASK = 5'h13;
  localparam logic [4:0] NUM_XCONTEXT = 5'h14;
  localparam logic [4:0] NUM_DIAG = 5'h16;
  localparam logic [4:0] NUM_PERF = 5'h19;
  localparam logic [4:0] NUM_PARITY = 5'h1a;
  localparam logic [4:0] NUM_CACHE = 5'h1b;
  localparam logic [4:0] NUM_TAG = 5'h1c;
  localparam logic [4:0] NUM_DATA = 5'h1d;

  // subnumbers
  localparam logic [2:0] SEL_0 = 3'h0;
  localparam logic [2:0] SEL_1 = 3'h1;
  localparam logic [2:0] SEL_2 = 3'h2;
  localparam logic [2:0] SEL_3 = 3'h3;

  // field positions
  localparam int STATUS_CU0_BIT = 28;
  localparam int DIAG_BTB_OFF_BIT = 0;
  localparam int DIAG_RAS_OFF_BIT = 1;
  localparam int DIAG_ITLB_CLR_BIT = 2;
  localparam int EV_DENIED_BIT = 0;
  localparam int EV_UNMAPPED_BIT = 1;
  localparam int EV_WRAP_BIT = 2;
  localparam int EV_W = 3;
  localparam int DIAG_W = 2;

  // reset values
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [5:0] INDEX_RST = 6'h00;
  localparam logic [5:0] WIRED_RST = 6'h00;
  localparam logic [1:0] DIAG_RST = 2'h0;
  localparam logic [2:0] EV_RST = 3'h0;

  // access sequencing
  typedef enum logic [1:0] {
    SCC_IDLE,
    SCC_FETCH,
    SCC_ANSWER
  } scc_phase_t;

  // what a register address selects
  typedef enum logic [3:0] {
    SCC_K_NONE,
    SCC_K_INDEX,
    SCC_K_RANDOM,
    SCC_K_WIRED,
    SCC_K_STATUS,
    SCC_K_PRID,
    SCC_K_DIAG,
    SCC_K_EVENT,
    SCC_K_EVMASK,
    SCC_K_STORE
  } scc_kind_t;

endpackage

// *** src/scc_register_bank.sv ***
// system control coprocessor register bank with move-to/from access port
//
// Functional notes
// - word and dword move-from instructions return the selected register
// - word and dword move-to instructions load the selected register
// - access allowed only in kernel mode or with status bit 28 set
// - access without permission raises coprocessor-unavailable, nothing done
// - number 0 sub 0 holds the translation entry index
// - number 1 sub 0 is the pseudo-random replacement index
// - number 6 sets how many low entries random replacement skips
// - number 5 sub 1 large-page flag, sub 0 page size mask
// - number 12 decodes subs 0 status, 1 interrupt control, 2 shadow bank
// - number 15 sub 1 holds the exception vector base
// - number 20 is the 64-bit table pointer, number 4 the 32-bit one
// - number 22 enables branch predictors and clears instruction tlb
// - numbers 26 and 27 hold parity and cache check control/status
// - random index loads its upper bound at restart
// - random index never goes below the fixed-entry count; here a count above the upper bound holds it at that bound
// - random upper bound is entry count minus one, at most 63
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scc_register_bank #(
  parameter int TLB_ENTRIES = 64,
  parameter logic [31:0] REVISION_ID = 32'h0000_5a01 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [scc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [scc_pkg::DATA_W-1:0] avs_writedata,
  output logic [scc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dword_op,
  input wire logic kernel_mode,
  input wire logic instr_retire,
  output logic copunusable,
  output logic irq,
  output logic [scc_pkg::IDX_W-1:0] tlb_index_sel,
  output logic [scc_pkg::IDX_W-1:0] tlb_random_sel,
  output logic [scc_pkg::IDX_W-1:0] tlb_fixed_count,
  output logic btb_enable,
  output logic ras_enable,
  output logic itlb_clear
);

  // upper bound of the random index, truncated to the index width
  localparam logic [scc_pkg::IDX_W-1:0] RANDOM_TOP =
    scc_pkg::IDX_W'(TLB_ENTRIES - 1);

  // all block state in one word, so one process registers every field
  typedef struct packed {
    scc_pkg::scc_phase_t phase;
    logic [scc_pkg::DATA_W-1:0] rdata;
    logic [scc_pkg::IDX_W-1:0] index;
    logic [scc_pkg::IDX_W-1:0] random;
    logic [scc_pkg::IDX_W-1:0] wired;
    logic [31:0] status;
    logic [scc_pkg::DIAG_W-1:0] diag;
    logic itlb_clear;
    logic unavail;
    logic [scc_pkg::EV_W-1:0] ev;
    logic [scc_pkg::EV_W-1:0] ev_mask;
  } scc_state_t;

  scc_state_t st;
  scc_state_t next_st;

  logic [scc_pkg::NUM_W-1:0] num;
  logic [scc_pkg::SEL_W-1:0] sel;
  scc_pkg::scc_kind_t kind;
  logic permit;
  logic [scc_pkg::DATA_W-1:0] wdata;
  logic [scc_pkg::DATA_W-1:0] mem_rdata;
  logic [scc_pkg::DATA_W-1:0] mux;
  logic mem_we;
  logic [scc_pkg::EV_W-1:0] ev_set;
  logic ev_clr;

  // subnumbers above 3 never reach storage: the decode refuses them first
  assign num = avs_address[scc_pkg::NUM_LSB +: scc_pkg::NUM_W];
  assign sel = avs_address[scc_pkg::SEL_LSB +: scc_pkg::SEL_W];

  // address decode; unlisted numbers at sub 0 fall to storage, anything else to none
  function automatic scc_pkg::scc_kind_t decode(
    input logic [4:0] n,
    input logic [2:0] s
  );
    scc_pkg::scc_kind_t k;
    k = scc_pkg::SCC_K_NONE;
    case (n)
      scc_pkg::NUM_INDEX: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_INDEX;
      end
      scc_pkg::NUM_RANDOM: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_RANDOM;
      end
      scc_pkg::NUM_PAGE: begin
        if (s <= scc_pkg::SEL_1) k = scc_pkg::SCC_K_STORE;
      end
      scc_pkg::NUM_WIRED: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_WIRED;
      end
      scc_pkg::NUM_STATUS: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_STATUS;
        else if (s <= scc_pkg::SEL_2) k = scc_pkg::SCC_K_STORE;
      end
      scc_pkg::NUM_VECTOR: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_PRID;
        else if (s == scc_pkg::SEL_1) k = scc_pkg::SCC_K_STORE;
      end
      scc_pkg::NUM_CONFIG, scc_pkg::NUM_PERF: begin
        if (s <= scc_pkg::SEL_3) k = scc_pkg::SCC_K_STORE;
      end
      scc_pkg::NUM_TAG, scc_pkg::NUM_DATA: begin
        if (s <= scc_pkg::SEL_1) k = scc_pkg::SCC_K_STORE;
      end
      scc_pkg::NUM_EVENT: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_EVENT;
      end
      scc_pkg::NUM_EVMASK: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_EVMASK;
      end
      scc_pkg::NUM_DIAG: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_DIAG;
      end
      5'h15: begin
        k = scc_pkg::SCC_K_NONE;
      end
      scc_pkg::NUM_CONTEXT, scc_pkg::NUM_XCONTEXT,
      scc_pkg::NUM_PARITY, scc_pkg::NUM_CACHE: begin
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_STORE;
      end
      default: begin
        // remaining plain numbers, other than the reserved number 21
        if (s == scc_pkg::SEL_0) k = scc_pkg::SCC_K_STORE;
      end
    endcase
    return k;
  endfunction

  // decoded straight off the held address; the master keeps it stable
  assign kind = decode(num, sel);

  // kernel mode or the usable bit opens the bank
  assign permit = kernel_mode | st.status[scc_pkg::STATUS_CU0_BIT];

  // word moves carry the low word, sign-extended into the register
  assign wdata = dword_op ? avs_writedata :
    {{scc_pkg::WORD_W{avs_writedata[31]}}, avs_writedata[31:0]};

  // storage writes only on the answering edge of a permitted move
  assign mem_we = (st.phase == scc_pkg::SCC_ANSWER) & avs_write & permit &
    (kind == scc_pkg::SCC_K_STORE);

  scc_store #(
    .W(scc_pkg::DATA_W),
    .AW(scc_pkg::SLOT_W)
  ) u_store (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .rd_addr({sel[1:0], num}),
    .wr_en(mem_we),
    .wr_addr({sel[1:0], num}),
    .wr_data(wdata),
    .rd_data(mem_rdata)
  );

  // read data selection, before word narrowing
  always_comb begin
    case (kind)
      scc_pkg::SCC_K_INDEX: mux = {58'h0, st.index};
      scc_pkg::SCC_K_RANDOM: mux = {58'h0, st.random};
      scc_pkg::SCC_K_WIRED: mux = {58'h0, st.wired};
      scc_pkg::SCC_K_STATUS: mux = {{32{st.status[31]}}, st.status};
      scc_pkg::SCC_K_PRID: mux = {32'h0, REVISION_ID};
      scc_pkg::SCC_K_DIAG: mux = {62'h0, st.diag};
      scc_pkg::SCC_K_EVENT: mux = {61'h0, st.ev};
      scc_pkg::SCC_K_EVMASK: mux = {61'h0, st.ev_mask};
      scc_pkg::SCC_K_STORE: mux = mem_rdata;
      default: mux = '0;
    endcase
  end

  // next state: access sequencing, random walk, events
  always_comb begin
    next_st = st;
    next_st.itlb_clear = 1'b0;
    next_st.unavail = 1'b0;
    ev_set = '0;
    ev_clr = 1'b0;

    // random steps down per retired instruction, wrapping at the floor
    if (instr_retire) begin
      if (st.random <= st.wired) begin
        next_st.random = RANDOM_TOP;
        ev_set[scc_pkg::EV_WRAP_BIT] = 1'b1;
      end else begin
        next_st.random = st.random - 6'h01;
      end
    end

    // permission is judged again at the answer, so a status write that
    // drops the usable bit governs the very next access
    case (st.phase)
      scc_pkg::SCC_IDLE: begin
        if (avs_read || avs_write) begin
          next_st.phase = scc_pkg::SCC_FETCH;
        end
      end
      scc_pkg::SCC_FETCH: begin
        // denied reads return zero rather than leaking state
        if (!permit) begin
          next_st.rdata = '0;
        end else if (dword_op) begin
          next_st.rdata = mux;
        end else begin
          next_st.rdata = {{scc_pkg::WORD_W{mux[31]}}, mux[31:0]};
        end
        next_st.phase = scc_pkg::SCC_ANSWER;
      end
      scc_pkg::SCC_ANSWER: begin
        next_st.phase = scc_pkg::SCC_IDLE;
        if (!permit) begin
          next_st.unavail = 1'b1;
          ev_set[scc_pkg::EV_DENIED_BIT] = 1'b1;
        end else if (kind == scc_pkg::SCC_K_NONE) begin
          ev_set[scc_pkg::EV_UNMAPPED_BIT] = 1'b1;
        end else if (avs_read) begin
          ev_clr = (kind == scc_pkg::SCC_K_EVENT);
        end else begin
          case (kind)
            scc_pkg::SCC_K_INDEX: begin
              next_st.index = wdata[scc_pkg::IDX_W-1:0];
            end
            scc_pkg::SCC_K_WIRED: begin
              // a new floor restarts the walk from the top
              next_st.wired = wdata[scc_pkg::IDX_W-1:0];
              next_st.random = RANDOM_TOP;
            end
            scc_pkg::SCC_K_STATUS: begin
              next_st.status = wdata[31:0];
            end
            scc_pkg::SCC_K_DIAG: begin
              next_st.diag = wdata[scc_pkg::DIAG_W-1:0];
              next_st.itlb_clear = wdata[scc_pkg::DIAG_ITLB_CLR_BIT];
            end
            scc_pkg::SCC_K_EVMASK: begin
              next_st.ev_mask = wdata[scc_pkg::EV_W-1:0];
            end
            default: begin
              // read-only numbers and storage need nothing here
              next_st.index = st.index;
            end
          endcase
        end
      end
      default: begin
        next_st.phase = scc_pkg::SCC_IDLE;
      end
    endcase

    // a fresh event beats the read that clears the register
    next_st.ev = (ev_clr ? '0 : st.ev) | ev_set;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st.phase <= scc_pkg::SCC_IDLE;
      st.rdata <= '0;
      st.index <= scc_pkg::INDEX_RST;
      // top, not zero, so the first random victim after restart is known
      st.random <= RANDOM_TOP;
      st.wired <= scc_pkg::WIRED_RST;
      st.status <= scc_pkg::STATUS_RST;
      st.diag <= scc_pkg::DIAG_RST;
      st.itlb_clear <= 1'b0;
      st.unavail <= 1'b0;
      st.ev <= scc_pkg::EV_RST;
      st.ev_mask <= scc_pkg::EV_RST;
    end else begin
      st <= next_st;
    end
  end

  // the master is held off until the third cycle of each access
  // no request, no waitrequest: an idle bus never sees the bank stall
  assign avs_waitrequest = (avs_read | avs_write) &
    (st.phase != scc_pkg::SCC_ANSWER);
  assign avs_readdata = st.rdata;
  assign copunusable = st.unavail;
  assign irq = |(st.ev & st.ev_mask);
  assign tlb_index_sel = st.index;
  assign tlb_random_sel = st.random;
  assign tlb_fixed_count = st.wired;
  // enables are stored as off bits so that a cleared state means enabled
  assign btb_enable = ~st.diag[scc_pkg::DIAG_BTB_OFF_BIT];
  assign ras_enable = ~st.diag[scc_pkg::DIAG_RAS_OFF_BIT];
  assign itlb_clear = st.itlb_clear;

endmodule
`default_nettype wire

// *** src/scc_store.sv ***
// plain read/write storage for the general control registers
`timescale 1ns/1ps
`default_nettype none
module scc_store #(
  parameter int W = 64,
  parameter int AW = 7
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [AW-1:0] rd_addr,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] rd_data
);

  typedef struct packed {
    logic [(1<<AW)-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } scc_store_t;

  scc_store_t st;
  scc_store_t next_st;

  // registered read port, so read data always lag the address by one edge
  always_comb begin
    next_st = st;
    next_st.rdata = st.mem[rd_addr];
    if (wr_en) begin
      next_st.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rdata;

endmodule
`default_nettype wire

// *** verif/scc_bank_properties.sv ***
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module scc_bank_properties #(
  parameter int TLB_ENTRIES = 64
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [scc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic kernel_mode,
  input wire logic instr_retire,
  input wire logic copunusable,
  input wire logic [scc_pkg::IDX_W-1:0] tlb_random_sel,
  input wire logic [scc_pkg::IDX_W-1:0] tlb_fixed_count,
  input wire logic btb_enable,
  input wire logic itlb_clear
);
  localparam logic [5:0] TOP = 6'(TLB_ENTRIES - 1);
  logic req;
  logic ans;
  logic diag_wr;
  // answer edge of a request, and a diag write landing on it
  assign req = avs_read | avs_write;
  assign ans = req & ~avs_waitrequest;
  assign diag_wr = ans & avs_write & (avs_address == 8'h16);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_two_waits: assert property (
    $rose(req) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after two wait cycles");
  a_kernel_ok: assert property (
    $rose(req) && kernel_mode |-> ##3 !copunusable)
    else $error("kernel access was refused");
  a_deny_pulse: assert property (
    copunusable |-> $past(ans) && !$past(kernel_mode))
    else $error("denial pulse without a user access");
  a_random_top: assert property (
    $rose(nrst) |-> tlb_random_sel == TOP)
    else $error("random index not at top after reset");
  a_random_step: assert property (
    instr_retire && !avs_write && tlb_random_sel > tlb_fixed_count
    |=> tlb_random_sel == $past(tlb_random_sel) - 6'h01)
    else $error("random index did not step down");
  a_random_wrap: assert property (
    instr_retire && !avs_write && tlb_random_sel <= tlb_fixed_count
    |=> tlb_random_sel == TOP)
    else $error("random index did not wrap to top");
  a_random_floor: assert property (
    tlb_random_sel >= tlb_fixed_count || tlb_random_sel == TOP)
    else $error("random index below fixed count");
  a_itlb_pulse: assert property (
    itlb_clear |-> $past(diag_wr))
    else $error("itlb clear without diag write");
  a_btb_write: assert property (
    $changed(btb_enable) |-> $past(diag_wr))
    else $error("btb enable moved without diag write");
endmodule
bind scc_register_bank scc_bank_properties #(.TLB_ENTRIES(TLB_ENTRIES))
  u_props (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
  .avs_waitrequest, .kernel_mode, .instr_retire, .copunusable,
  .tlb_random_sel, .tlb_fixed_count, .btb_enable, .itlb_clear);
`default_nettype wire

// *** verif/scc_pipe_model.sv ***
// pipeline-side model issuing move-to and move-from requests
`timescale 1ns/1ps
`default_nettype none
module scc_pipe_model (
  input wire logic sys_clk,
  input wire logic avs_waitrequest,
  input wire logic [63:0] avs_readdata,
  output var logic [7:0] avs_address,
  output var logic avs_read,
  output var logic avs_write,
  output var logic [63:0] avs_writedata,
  output var logic dword_op,
  output var logic kernel_mode
);
  // quiet bus at time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 64'h0;
    dword_op = 1'b0;
    kernel_mode = 1'b0;
  end
  // one move; waitrequest and read data are taken at the answering edge
  task automatic access(input logic wr, input logic [7:0] a,
      input logic [63:0] d, input logic dw, input logic km,
      output logic [63:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    dword_op <= dw;
    kernel_mode <= km;
    // bank state moves by non-blocking update, so reads right after the
    // edge still see what stood at that edge
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest);
    q = avs_readdata;
    // released lines show inverted leftovers, not the old value
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0] a;
    logic [63:0] d;
    logic [63:0] e;
  } scc_row_t;
  localparam scc_row_t ROWS [13] = '{
    '{8'h00, 64'hffff, 64'h3f}, '{8'h01, 64'h0, 64'h3f},
    '{8'h05, 64'h0123_4567_89ab_cdef, 64'h0123_4567_89ab_cdef},
    '{8'h25, 64'hfedc_ba98_7654_3210, 64'hfedc_ba98_7654_3210},
    '{8'h2c, 64'h1111, 64'h1111}, '{8'h4c, 64'h2222, 64'h2222},
    '{8'h2f, 64'h8000_0000_0000_1000, 64'h8000_0000_0000_1000},
    '{8'h14, 64'h5555_aaaa_0000_ffff, 64'h5555_aaaa_0000_ffff},
    '{8'h04, 64'h0404, 64'h0404}, '{8'h1a, 64'h1a1a, 64'h1a1a},
    '{8'h1b, 64'h1b1b, 64'h1b1b}, '{8'h15, 64'hffff, 64'h0},
    '{8'h6c, 64'hffff, 64'h0}};
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_retire = 1'b0;
  logic [7:0] avs_address;
  logic avs_read, avs_write, dword_op, kernel_mode, avs_waitrequest;
  logic [63:0] avs_writedata, avs_readdata, q;
  logic copunusable, irq, btb_enable, ras_enable, itlb_clear;
  logic [5:0] tlb_index_sel, tlb_random_sel, tlb_fixed_count;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  scc_pipe_model u_pipe (.sys_clk, .avs_waitrequest, .avs_readdata,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .dword_op,
    .kernel_mode);
  scc_register_bank u_dut (.sys_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .dword_op,
    .kernel_mode, .instr_retire, .copunusable, .irq, .tlb_index_sel,
    .tlb_random_sel, .tlb_fixed_count, .btb_enable, .ras_enable,
    .itlb_clear);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one instruction retired
  task automatic retire;
    @(posedge sys_clk);
    instr_retire <= 1'b1;
    @(posedge sys_clk);
    instr_retire <= 1'b0;
    @(negedge sys_clk);
  endtask
  // hang guard, runs take a few hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk(64'(tlb_random_sel), 64'h3f);
    chk(64'(tlb_index_sel), 64'h0);
    foreach (ROWS[i]) begin
      u_pipe.access(1'b1, ROWS[i].a, ROWS[i].d, 1'b1, 1'b1, q);
      u_pipe.access(1'b0, ROWS[i].a, 64'h0, 1'b1, 1'b1, q);
      chk(q, ROWS[i].e);
    end
    chk(64'(tlb_index_sel), 64'h3f);
    // word move sign-extends the low half, on the way in and out
    u_pipe.access(1'b1, 8'h04, 64'h8000_0001, 1'b0, 1'b1, q);
    u_pipe.access(1'b0, 8'h04, 64'h0, 1'b1, 1'b1, q);
    chk(q, 64'hffff_ffff_8000_0001);
    u_pipe.access(1'b0, 8'h05, 64'h0, 1'b0, 1'b1, q);
    chk(q, 64'hffff_ffff_89ab_cdef);
    // user mode without the usable bit is refused and flagged
    u_pipe.access(1'b1, 8'h00, 64'h5, 1'b1, 1'b0, q);
    @(negedge sys_clk);
    chk(64'(copunusable), 64'h1);
    u_pipe.access(1'b0, 8'h00, 64'h0, 1'b1, 1'b0, q);
    chk(q, 64'h0);
    u_pipe.access(1'b1, 8'h0c, 64'h1000_0000, 1'b0, 1'b1, q);
    u_pipe.access(1'b0, 8'h00, 64'h0, 1'b1, 1'b0, q);
    chk(q, 64'h3f);
    @(negedge sys_clk);
    chk(64'(copunusable), 64'h0);
    u_pipe.access(1'b0, 8'h0c, 64'h0, 1'b1, 1'b0, q);
    chk(q, 64'h1000_0000);
    // events stay hidden until unmasked, read clears them
    chk(64'(irq), 64'h0);
    u_pipe.access(1'b1, 8'h13, 64'h7, 1'b1, 1'b1, q);
    @(negedge sys_clk);
    chk(64'(irq), 64'h1);
    u_pipe.access(1'b0, 8'h12, 64'h0, 1'b1, 1'b1, q);
    chk(q, 64'h3);
    @(negedge sys_clk);
    chk(64'(irq), 64'h0);
    // fixed count reloads the random index, then steps and wraps
    u_pipe.access(1'b1, 8'h06, 64'h3e, 1'b1, 1'b1, q);
    @(negedge sys_clk);
    chk({58'h0, tlb_fixed_count}, 64'h3e);
    chk(64'(tlb_random_sel), 64'h3f);
    retire();
    chk(64'(tlb_random_sel), 64'h3e);
    retire();
    chk(64'(tlb_random_sel), 64'h3f);
    chk(64'(irq), 64'h1);
    u_pipe.access(1'b0, 8'h12, 64'h0, 1'b1, 1'b1, q);
    chk(q, 64'h4);
    // diag turns predictors off; clear bit pulses and reads back zero
    u_pipe.access(1'b1, 8'h16, 64'h7, 1'b1, 1'b1, q);
    @(negedge sys_clk);
    chk({62'h0, btb_enable, ras_enable}, 64'h0);
    chk(64'(itlb_clear), 64'h1);
    u_pipe.access(1'b0, 8'h16, 64'h0, 1'b1, 1'b1, q);
    chk(q, 64'h3);
    // move random off its top so the reset has something to restore
    retire();
    chk(64'(tlb_random_sel), 64'h3e);
    // second reset mid-run restores defaults
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk({52'h0, tlb_random_sel, tlb_index_sel}, 64'hfc0);
    chk({62'h0, btb_enable, ras_enable}, 64'h3);
    u_pipe.access(1'b0, 8'h05, 64'h0, 1'b1, 1'b1, q);
    chk(q, 64'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
